/* File: bench/ccrr_board.sv */
`timescale 1ns/1ps
// board reset source: pulls reset low on request and drives the ratio straps around it
module ccrr_board (
	input wire logic clk,
	input wire logic kick,
	input wire logic [1:0] code,
	input wire logic [7:0] hold,
	output logic rst_b,
	output logic [1:0] strap
);
	// straps must sit still 20 us before release: 2000 cycles of the 10 ns bench clock
	localparam int STRAP_SETUP = 2000;
	logic kick_q;
	logic [15:0] cnt;
	// power-up pulse of three cycles; the input clock already runs from time zero
	initial begin
		rst_b = 1'b0;
		strap = 2'h0;
		kick_q = 1'b0;
		cnt = 16'h0003;
	end
	// straps move only as reset falls and stay put through release, so sampling sees one code
	always @(posedge clk) begin
		if (kick !== kick_q) begin
			kick_q <= kick;
			strap <= code;
			rst_b <= 1'b0;
			// low time also covers the strap setup, so a short hold still keeps both rules
			cnt <= 16'((hold < 8'h04) ? 8'h04 : hold) + 16'(STRAP_SETUP);
		end else if (cnt != 16'h0000) begin
			cnt <= cnt - 16'h0001;
			if (cnt == 16'h0001) rst_b <= 1'b1;
		end
	end
endmodule

/* File: bench/core_clock_and_reset_release_tb.sv */
`timescale 1ns/1ps
`include "ccrr_regs.svh"
module core_clock_and_reset_release_tb;
	localparam int RIN = 4;
	logic clk, awvalid, wvalid, bready, arvalid, rready, kick;
	logic [7:0] awaddr, araddr, hold;
	logic [31:0] wdata, d;
	logic [3:0] wstrb;
	logic [1:0] code, r, cur;
	wire logic rst_b, awready, wready, bvalid, arready, rvalid, core_rst_b, pclk, spiclk;
	wire logic [1:0] strap, bresp, rresp, sclk;
	wire logic [31:0] rdata;
	wire logic [5:0] pll_mult;
	int n_mismatch = 0;
	int n_compared = 0;
	int seed = 32'h34217b0e;
	int i, m, pm, v;
	int m_tab[5] = '{6, 24, 5, 25, 12};
	// input period left at its slow default, never the fastest one
	ccrr_top #(.RESET_IN_CYCLES(RIN)) dut (.CLK(clk), .RST_B(rst_b), .RATIO_STRAP_PINS(strap),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .PLL_MULT(pll_mult), .CORE_RST_B(core_rst_b),
		.PCLK(pclk), .SCLK(sclk), .SPICLK(spiclk));
	ccrr_board board (.clk(clk), .kick(kick), .code(code), .hold(hold), .rst_b(rst_b),
		.strap(strap));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic int ratio(input logic [1:0] c);
		case (c)
			2'h1: return 32;
			2'h2: return 16;
			default: return 6;
		endcase
	endfunction
	function automatic logic [31:0] stat(input logic [1:0] c);
		return 32'h10000 | (32'(ratio(c)) << 8) | 32'(c);
	endfunction
	function automatic logic pick(input int s);
		return (s == 0) ? pclk : (s == 1) ? spiclk : sclk[s-2];
	endfunction
	task report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task give_up;
		n_mismatch++;
		$display("wait limit used up at %0t", $time);
		report_and_stop;
	endtask
	task step;
		@(posedge clk);
		#1;
	endtask
	// one write, address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
		logic aw, w;
		int k;
		@(posedge clk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		for (k = 0; k < 64; k++) begin
			@(posedge clk);
			if (awready && !aw) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				return;
			end
		end
		give_up;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar;
		int k;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ar = 1'b0;
		for (k = 0; k < 64; k++) begin
			@(posedge clk);
			if (arready && !ar) begin
				ar = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				check(rdata, ed);
				check(32'(rresp), 32'(er));
				rready <= 1'b0;
				return;
			end
		end
		give_up;
	endtask
	// board reset with a new strap code, then time the core reset release
	task do_reset(input logic [1:0] c);
		int k, n, q;
		q = ratio(c);
		cur = c;
		@(posedge clk);
		code <= c;
		hold <= 8'h04 + 8'($random(seed) & 7);
		kick <= ~kick;
		for (k = 0; k < 20 && rst_b !== 1'b0; k++) step;
		if (k >= 20) give_up;
		step;
		check(32'({core_rst_b, pclk, spiclk, sclk, pll_mult}), 32'h6);
		for (k = 0; k < 2100 && rst_b !== 1'b1; k++) step;
		for (n = 0; n < 400 && core_rst_b !== 1'b1; n++) step;
		if (k >= 2100 || n >= 400) give_up;
		// one extra input period is allowed for a missed setup, plus a few sync edges
		check((n < RIN*q+2 || n > RIN*q+q+6) ? n : RIN*q+2, RIN*q+2);
		check(32'(pll_mult), q);
		rchk(`CCRR_STATUS_OFF, stat(c), `CCRR_RESP_OKAY);
	endtask
	// half periods of one clock output, the first two phases skipped while a divider restarts
	task half(input int s, input int exp);
		logic lv;
		int k, n;
		for (k = 0; k < 4; k++) begin
			lv = pick(s);
			for (n = 0; pick(s) === lv && n < 80; n++) step;
			if (k > 1) check(n, exp);
		end
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, kick} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		code = 2'h0;
		hold = 8'h04;
		for (i = 0; i < 4; i++) do_reset(2'(i));
		do_reset(2'($random(seed) & 3));
		$display("reset tests done");
		rchk(`CCRR_POWER_MGMT_CONTROL_OFF, 32'h0, `CCRR_RESP_OKAY);
		rchk(`CCRR_SPI_OFF, 32'h4, `CCRR_RESP_OKAY);
		rchk(`CCRR_SER_BASE, 32'h1, `CCRR_RESP_OKAY);
		rchk(`CCRR_SER_BASE + 8'h04, 32'h1, `CCRR_RESP_OKAY);
		rchk(8'h40, 32'h0, `CCRR_RESP_SLVERR);
		wr(8'h44, 32'h5, r);
		check(32'(r), 32'(`CCRR_RESP_SLVERR));
		wr(`CCRR_STATUS_OFF, 32'hffffffff, r);
		check(32'(r), 32'(`CCRR_RESP_OKAY));
		rchk(`CCRR_STATUS_OFF, stat(cur), `CCRR_RESP_OKAY);
		$display("register tests done");
		half(0, 1);
		half(1, 4);
		half(2, 1);
		half(3, 1);
		for (i = 0; i < 6; i++) begin
			v = 1 + ($random(seed) & 7);
			wr((i % 3 == 0) ? `CCRR_SPI_OFF : `CCRR_SER_BASE + 8'(4 * (i % 3 - 1)), v, r);
			half((i % 3 == 0) ? 1 : i % 3 + 1, v);
		end
		$display("divider tests done");
		pm = 32'(pll_mult);
		foreach (m_tab[j]) begin
			m = m_tab[j];
			wr(`CCRR_POWER_MGMT_CONTROL_OFF, 32'h100 | m, r);
			v = (m * `CCRR_TCCLK_MIN_PS <= `CCRR_INPUT_CLOCK_PERIOD_PS &&
				m * `CCRR_TCCLK_MAX_PS >= `CCRR_INPUT_CLOCK_PERIOD_PS);
			check(32'(r), v ? 32'(`CCRR_RESP_OKAY) : 32'(`CCRR_RESP_SLVERR));
			pm = v ? m : pm;
			repeat (2) step;
			check(32'(pll_mult), pm);
		end
		wr(`CCRR_POWER_MGMT_CONTROL_OFF, 32'h0, r);
		repeat (2) step;
		check(32'(pll_mult), ratio(cur));
		$display("multiplier tests done");
		report_and_stop;
	end
endmodule

/* File: hdl/ccrr_div.sv */
`timescale 1ns/1ps
`include "ccrr_regs.svh"
module ccrr_div (
	input wire logic clk,
	input wire logic rst_b,
	ccrr_div_if.div port
);
	typedef struct packed {
		logic [`CCRR_DIV_W-1:0] cnt;
		logic clk_o;
	} ccrr_div_st_t;

	ccrr_div_st_t s_r;
	ccrr_div_st_t s_nxt;

	// half period is ratio core cycles, so the full period is ratio peripheral cycles
	always_comb begin
		s_nxt = s_r;
		if (!port.run || port.ratio == '0) begin
			s_nxt.cnt = '0;
			s_nxt.clk_o = 1'b0;
		end else if (s_r.cnt >= port.ratio - 16'h1) begin
			s_nxt.cnt = '0;
			s_nxt.clk_o = ~s_r.clk_o;
		end else begin
			s_nxt.cnt = s_r.cnt + 16'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign port.clk_o = s_r.clk_o;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_div_idle_low: assert property (!port.run |=> !port.clk_o)
		else $error("divider clock not low while stopped");
	a_div_edge_due: assert property ((port.run && port.ratio != '0 &&
		s_r.cnt == port.ratio - 16'h1) |=> port.clk_o != $past(port.clk_o))
		else $error("divider clock missed its edge");
endmodule

/* File: hdl/ccrr_top.sv */
`timescale 1ns/1ps
`include "ccrr_regs.svh"
module ccrr_top #(
	parameter int NSER = 2,
	parameter int AW = 8,
	parameter int RESET_IN_CYCLES = `CCRR_RST_IN_CYCLES,
	parameter int INPUT_CLOCK_PERIOD_PS = `CCRR_INPUT_CLOCK_PERIOD_PS
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [1:0] RATIO_STRAP_PINS,
	input wire logic [AW-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [AW-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	output logic [5:0] PLL_MULT,
	output logic CORE_RST_B,
	output logic PCLK,
	output logic [NSER-1:0] SCLK,
	output logic SPICLK
);
	typedef struct packed {
		logic [1:0] sync;
		ccrr_pkg::ccrr_rst_st_t st;
		logic [23:0] cnt;
		logic [1:0] strap;
		logic [5:0] pm_mult;
		logic pm_sw;
		logic [15:0] spi_rate;
		logic [NSER-1:0][15:0] ser_div;
		logic [5:0] ratio;
		logic core_rst_b;
		logic pclk;
		logic aw_got;
		logic w_got;
		logic [AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ccrr_state_t;

	ccrr_state_t s_r;
	ccrr_state_t s_nxt;
	logic [5:0] act_ratio;
	logic [23:0] rst_target;

	// byte-lane merge of a write into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// predicted core period for a multiplier must stay inside the legal window
	function automatic logic mult_ok(input logic [5:0] m);
		int p;
		p = int'(m);
		return (m != 6'h0) && (p * `CCRR_TCCLK_MIN_PS <= INPUT_CLOCK_PERIOD_PS) &&
			(p * `CCRR_TCCLK_MAX_PS >= INPUT_CLOCK_PERIOD_PS);
	endfunction

	// register read mux; unmapped addresses answer with an error
	function automatic logic [33:0] rd_word(input ccrr_state_t s, input logic [AW-1:0] a);
		logic [31:0] d;
		logic [1:0] r;
		d = 32'h0;
		r = `CCRR_RESP_OKAY;
		if (a == AW'(`CCRR_POWER_MGMT_CONTROL_OFF)) begin
			d[`CCRR_PM_MULT_MSB:`CCRR_PM_MULT_LSB] = s.pm_mult;
			d[`CCRR_PM_SWSEL_BIT] = s.pm_sw;
		end else if (a == AW'(`CCRR_STATUS_OFF)) begin
			d[`CCRR_ST_STRAP_MSB:`CCRR_ST_STRAP_LSB] = s.strap;
			d[`CCRR_ST_RATIO_MSB:`CCRR_ST_RATIO_LSB] = s.ratio;
			d[`CCRR_ST_RUN_BIT] = s.core_rst_b;
		end else if (a == AW'(`CCRR_SPI_OFF)) begin
			d[15:0] = s.spi_rate;
		end else begin
			r = `CCRR_RESP_SLVERR;
			for (int i = 0; i < NSER; i++) begin
				if (a == AW'(`CCRR_SER_BASE + 4 * i)) begin
					d[15:0] = s.ser_div[i];
					r = `CCRR_RESP_OKAY;
				end
			end
		end
		return {r, d};
	endfunction

	// software ratio wins over the strap once selected
	assign act_ratio = s_r.pm_sw ? s_r.pm_mult : ccrr_pkg::ccrr_strap_ratio(s_r.strap);
	// release delay counted in core cycles: input periods times ratio, plus two core cycles
	assign rst_target = 24'(RESET_IN_CYCLES * int'(s_r.ratio) + `CCRR_RST_CORE_EXTRA);

	// reset sequencing, clock state and bus slave in one next-state block
	always_comb begin
		logic [31:0] mw;
		logic [33:0] rw;
		mw = 32'h0;
		rw = 34'h0;
		s_nxt = s_r;
		// first stage feeds only the second; the second alone is looked at
		s_nxt.sync = {s_r.sync[0], 1'b1};
		s_nxt.ratio = act_ratio;
		case (s_r.st)
			ccrr_pkg::CCRR_HOLD: begin
				s_nxt.core_rst_b = 1'b0;
				s_nxt.strap = RATIO_STRAP_PINS;
				s_nxt.cnt = 24'h0;
				if (s_r.sync[1]) begin
					s_nxt.st = ccrr_pkg::CCRR_COUNT;
				end
			end
			ccrr_pkg::CCRR_COUNT: begin
				s_nxt.cnt = s_r.cnt + 24'h1;
				if (s_r.cnt == rst_target - 24'h1) begin
					s_nxt.st = ccrr_pkg::CCRR_RUN;
					s_nxt.core_rst_b = 1'b1;
				end
			end
			ccrr_pkg::CCRR_RUN: begin
				s_nxt.core_rst_b = 1'b1;
			end
			default: begin
				s_nxt.st = ccrr_pkg::CCRR_HOLD;
				s_nxt.core_rst_b = 1'b0;
			end
		endcase
		// peripheral clock toggles every core cycle once the core runs
		s_nxt.pclk = s_r.core_rst_b ? ~s_r.pclk : 1'b0;
		// write address and data may arrive in either order
		if (AWVALID && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = AWADDR;
		end
		if (WVALID && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = WDATA;
			s_nxt.wstrb = WSTRB;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `CCRR_RESP_OKAY;
			if (s_r.awaddr == AW'(`CCRR_POWER_MGMT_CONTROL_OFF)) begin
				mw = merge({23'h0, s_r.pm_sw, 2'h0, s_r.pm_mult}, s_r.wdata, s_r.wstrb);
				// an illegal multiplier with the select bit set is refused whole, so a software ratio never leaves the range
				if (mw[`CCRR_PM_SWSEL_BIT] && !mult_ok(mw[`CCRR_PM_MULT_MSB:`CCRR_PM_MULT_LSB])) begin
					s_nxt.bresp = `CCRR_RESP_SLVERR;
				end else begin
					s_nxt.pm_mult = mw[`CCRR_PM_MULT_MSB:`CCRR_PM_MULT_LSB];
					s_nxt.pm_sw = mw[`CCRR_PM_SWSEL_BIT];
				end
			end else if (s_r.awaddr == AW'(`CCRR_STATUS_OFF)) begin
				s_nxt.bresp = `CCRR_RESP_OKAY;
			end else if (s_r.awaddr == AW'(`CCRR_SPI_OFF)) begin
				mw = merge({16'h0, s_r.spi_rate}, s_r.wdata, s_r.wstrb);
				s_nxt.spi_rate = mw[15:0];
			end else begin
				s_nxt.bresp = `CCRR_RESP_SLVERR;
				for (int i = 0; i < NSER; i++) begin
					if (s_r.awaddr == AW'(`CCRR_SER_BASE + 4 * i)) begin
						mw = merge({16'h0, s_r.ser_div[i]}, s_r.wdata, s_r.wstrb);
						s_nxt.ser_div[i] = mw[15:0];
						s_nxt.bresp = `CCRR_RESP_OKAY;
					end
				end
			end
		end
		if (s_r.bvalid && BREADY) begin
			s_nxt.bvalid = 1'b0;
		end
		// read answer is registered on the same edge that takes the address
		if (s_r.rvalid && RREADY) begin
			s_nxt.rvalid = 1'b0;
		end
		if (ARVALID && s_r.arready) begin
			rw = rd_word(s_r, ARADDR);
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rw[31:0];
			s_nxt.rresp = rw[33:32];
		end
		// ready flags depend on the next state so every output stays a flop
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
	end

	// single state register; async reset loads constants only
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			s_r <= '0;
			s_r.st <= ccrr_pkg::CCRR_HOLD;
			s_r.pm_mult <= `CCRR_POWER_MGMT_CONTROL_RST;
			s_r.spi_rate <= `CCRR_SPI_RST;
			s_r.ser_div <= {NSER{`CCRR_SER_RST}};
			s_r.ratio <= `CCRR_RATIO_00;
		end else begin
			s_r <= s_nxt;
		end
	end

	// one divider per serial port, all stopped until the core leaves reset
	genvar g;
	generate
		for (g = 0; g < NSER; g++) begin : g_ser
			ccrr_div_if ser_if ();
			assign ser_if.ratio = s_r.ser_div[g];
			assign ser_if.run = s_r.core_rst_b;
			ccrr_div u_div (
				.clk(CLK),
				.rst_b(RST_B),
				.port(ser_if.div)
			);
			assign SCLK[g] = ser_if.clk_o;
		end
	endgenerate

	// spi clock from the same divider shape
	ccrr_div_if spi_if ();
	assign spi_if.ratio = s_r.spi_rate;
	assign spi_if.run = s_r.core_rst_b;
	ccrr_div u_spi_div (
		.clk(CLK),
		.rst_b(RST_B),
		.port(spi_if.div)
	);
	assign SPICLK = spi_if.clk_o;

	// outputs straight from the state register
	assign AWREADY = s_r.awready;
	assign WREADY = s_r.wready;
	assign BVALID = s_r.bvalid;
	assign BRESP = s_r.bresp;
	assign ARREADY = s_r.arready;
	assign RVALID = s_r.rvalid;
	assign RDATA = s_r.rdata;
	assign RRESP = s_r.rresp;
	assign PLL_MULT = s_r.ratio;
	assign CORE_RST_B = s_r.core_rst_b;
	assign PCLK = s_r.pclk;

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);

	a_pclk_half_rate: assert property (CORE_RST_B && $past(CORE_RST_B) |=>
		PCLK != $past(PCLK))
		else $error("peripheral clock not at half core rate");
	a_core_rst_hold: assert property (s_r.st != ccrr_pkg::CCRR_RUN |-> !CORE_RST_B)
		else $error("core reset released early");
	a_release_on_count: assert property ((s_r.st == ccrr_pkg::CCRR_COUNT &&
		s_r.cnt == rst_target - 24'h1) |=> CORE_RST_B [*2])
		else $error("core reset not released at terminal count");
	a_count_start: assert property ((s_r.st == ccrr_pkg::CCRR_HOLD && s_r.sync[1]) |=>
		s_r.st == ccrr_pkg::CCRR_COUNT && s_r.cnt == 24'h0 ##1 s_r.cnt == 24'h1)
		else $error("release counter did not start");
	a_strap_ratio_map: assert property (!s_r.pm_sw |=>
		PLL_MULT == ccrr_pkg::ccrr_strap_ratio($past(s_r.strap)))
		else $error("strap ratio decode wrong");
	a_strap_sampled: assert property (s_r.st == ccrr_pkg::CCRR_HOLD |=>
		s_r.strap == $past(RATIO_STRAP_PINS))
		else $error("strap pins not sampled in reset");
	a_sw_ratio_used: assert property (s_r.pm_sw |=> PLL_MULT == $past(s_r.pm_mult))
		else $error("software ratio not applied");
	a_mult_in_range: assert property (s_r.pm_sw |-> mult_ok(s_r.pm_mult))
		else $error("software multiplier outside core period window");
	a_spi_ratio_feed: assert property (spi_if.ratio == s_r.spi_rate)
		else $error("spi divider not fed from rate register");
	a_bresp_stable: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped before accepted");

	c_core_released: cover property ($rose(CORE_RST_B));
	c_sw_ratio_set: cover property ($rose(s_r.pm_sw));
	c_range_refused: cover property (BVALID && BRESP == `CCRR_RESP_SLVERR);
	c_read_done: cover property (RVALID && RREADY);
endmodule

/* File: inc/ccrr_div_if.sv */
`timescale 1ns/1ps
`include "ccrr_regs.svh"
// ratio and run go to one divider, its clock comes back
interface ccrr_div_if;
	logic [`CCRR_DIV_W-1:0] ratio;
	logic run;
	logic clk_o;
	modport src (output ratio, output run, input clk_o);
	modport div (input ratio, input run, output clk_o);
endinterface

/* File: inc/ccrr_pkg.sv */
`include "ccrr_regs.svh"
package ccrr_pkg;
	// core reset sequencer states
	typedef enum logic [2:0] {
		CCRR_HOLD = 3'h1,
		CCRR_COUNT = 3'h2,
		CCRR_RUN = 3'h4
	} ccrr_rst_st_t;

	// strap code to core-to-input ratio; code 11 falls back to the slowest ratio
	function automatic logic [5:0] ccrr_strap_ratio(input logic [1:0] code);
		case (code)
			2'h1: ccrr_strap_ratio = `CCRR_RATIO_01;
			2'h2: ccrr_strap_ratio = `CCRR_RATIO_10;
			default: ccrr_strap_ratio = `CCRR_RATIO_00;
		endcase
	endfunction
endpackage

/* File: inc/ccrr_regs.svh */
`ifndef CCRR_REGS_SVH
`define CCRR_REGS_SVH

// register byte offsets
`define CCRR_POWER_MGMT_CONTROL_OFF 8'h00
`define CCRR_STATUS_OFF 8'h04
`define CCRR_SPI_OFF 8'h08
`define CCRR_SER_BASE 8'h10

// power-management control fields
`define CCRR_PM_MULT_LSB 0
`define CCRR_PM_MULT_MSB 5
`define CCRR_PM_SWSEL_BIT 8

// status fields
`define CCRR_ST_STRAP_LSB 0
`define CCRR_ST_STRAP_MSB 1
`define CCRR_ST_RATIO_LSB 8
`define CCRR_ST_RATIO_MSB 13
`define CCRR_ST_RUN_BIT 16

// reset values
`define CCRR_POWER_MGMT_CONTROL_RST 6'h00
`define CCRR_SPI_RST 16'h0004
`define CCRR_SER_RST 16'h0001

// strap ratio decode
`define CCRR_RATIO_00 6'h06
`define CCRR_RATIO_01 6'h20
`define CCRR_RATIO_10 6'h10

// timing
`define CCRR_RST_IN_CYCLES 4096
`define CCRR_RST_CORE_EXTRA 2
`define CCRR_TCCLK_MIN_PS 2500
`define CCRR_TCCLK_MAX_PS 10000
`define CCRR_INPUT_CLOCK_PERIOD_PS 60000
`define CCRR_DIV_W 16

// bus responses
`define CCRR_RESP_OKAY 2'h0
`define CCRR_RESP_SLVERR 2'h2

`endif
